/* design/amp_diag_pkg.sv */
// constants shared by the amplifier diagnostic control logic
package amp_diag_pkg;
  localparam int unsigned NUM_CH          = 4;
  localparam int unsigned CLK_HZ          = 50_000_000;
  // instruction bit positions
  localparam int unsigned IB1_OFFSET_EN   = 5;
  localparam int unsigned IB1_DIAG_EN     = 6;
  localparam int unsigned IB1_UNMUTE_REAR = 1;
  localparam int unsigned IB1_UNMUTE_FRNT = 2;
  localparam int unsigned IB2_SSR_EN      = 0;
  localparam int unsigned IB2_AC_EN       = 2;
  localparam int unsigned IB2_STBY_OFF    = 4;
  localparam int unsigned IB2_FAST_MUTE   = 5;
  localparam int unsigned IB2_LOW_TH      = 7;
  // diagnostic byte bit positions
  localparam int unsigned DB_AC_OPEN      = 5;
  localparam int unsigned DB_SSR_OFF      = 6;
  localparam int unsigned DB_THERM1       = 7;
  // reset values
  localparam logic [7:0]  IB1_RESET       = 8'h00;
  localparam logic [7:0]  IB2_RESET       = 8'h00;
  // ac confirmation pulse count
  localparam logic [1:0]  AC_CONFIRM_CNT  = 2'h3;
  // timing
  localparam int unsigned SSR_OFF_MS      = 40;
  localparam int unsigned SSR_OFF_CYC     = SSR_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned FAST_MUTE_US10  = 15;
  localparam int unsigned FAST_MUTE_CYC   = FAST_MUTE_US10 * (CLK_HZ / 10_000);
  localparam int unsigned NORM_MUTE_MS    = 20;
  localparam int unsigned NORM_MUTE_CYC   = NORM_MUTE_MS * (CLK_HZ / 1000);
  // fault codes with priority resolved
  typedef enum logic [2:0] {
    FLT_NONE   = 3'b000,
    FLT_OPEN   = 3'b001,
    FLT_ACROSS = 3'b010,
    FLT_GND    = 3'b011,
    FLT_VS     = 3'b100,
    FLT_BOTH   = 3'b101
  } fault_e;
endpackage

/* design/peak_sync.sv */
// two-flop synchroniser with rising-edge pulse for one channel input
`timescale 1ns/100ps
module peak_sync (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      level_q,
  output logic      rise
);
  logic meta_q;
  logic prev_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q  <= 1'b0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      meta_q  <= async_in;
      level_q <= meta_q;
      prev_q  <= level_q;
    end
  end

  assign rise = level_q & ~prev_q;
endmodule

/* design/amp_output_diagnostics_ctrl.sv */
// diagnostic control: ac load, dc offset, speaker safety, fault reporting
`timescale 1ns/100ps
module amp_output_diagnostics_ctrl
  import amp_diag_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic [7:0]          first_instruction_byte,
  input  wire logic [7:0]          second_instruction_byte,
  input  wire logic                instr_wr,
  input  wire logic                host_read,
  input  wire logic                standby_pin,
  input  wire logic                play_cmd,
  input  wire logic                turn_on_phase,
  input  wire logic [NUM_CH-1:0]   peak_above_hi,
  input  wire logic [NUM_CH-1:0]   peak_above_lo,
  input  wire logic [NUM_CH-1:0]   offset_over,
  input  wire logic [NUM_CH-1:0]   short_prot,
  input  wire logic [NUM_CH-1:0]   short_gnd,
  input  wire logic [NUM_CH-1:0]   short_vs,
  input  wire logic [NUM_CH-1:0]   short_across,
  input  wire logic [NUM_CH-1:0]   open_load,
  input  wire logic [2:0]          thermal_warn,
  output logic                     amp_enable,
  output logic                     mute_active,
  output logic                     fast_mute,
  output logic [NUM_CH-1:0]        ac_open_q,
  output logic [NUM_CH-1:0]        offset_fault_q,
  output logic [NUM_CH*3-1:0]      fault_code_q,
  output logic [7:0]               second_diagnostic_byte,
  output logic [2:0]               thermal_q
);

  // ==========================================================
  // input synchronisation
  // ==========================================================
  logic [NUM_CH-1:0] hi_rise, lo_rise;
  logic [NUM_CH-1:0] off_s1_q, off_q, sp_s1_q, sp_q;
  logic [NUM_CH-1:0] sg_s1_q, sg_q, sv_s1_q, sv_q, sa_s1_q, sa_q, ol_s1_q, ol_q;
  logic [2:0]        th_s1_q, th_q;
  logic              stby_s1_q, stby_q;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_sync
      peak_sync u_hi (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (peak_above_hi[g]),
        .level_q  (),
        .rise     (hi_rise[g])
      );
      peak_sync u_lo (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (peak_above_lo[g]),
        .level_q  (),
        .rise     (lo_rise[g])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      off_s1_q  <= '0;
      off_q     <= '0;
      sp_s1_q   <= '0;
      sp_q      <= '0;
      sg_s1_q   <= '0;
      sg_q      <= '0;
      sv_s1_q   <= '0;
      sv_q      <= '0;
      sa_s1_q   <= '0;
      sa_q      <= '0;
      ol_s1_q   <= '0;
      ol_q      <= '0;
      th_s1_q   <= '0;
      th_q      <= '0;
      stby_s1_q <= 1'b0;
      stby_q    <= 1'b0;
    end else begin
      off_s1_q  <= offset_over;
      off_q     <= off_s1_q;
      sp_s1_q   <= short_prot;
      sp_q      <= sp_s1_q;
      sg_s1_q   <= short_gnd;
      sg_q      <= sg_s1_q;
      sv_s1_q   <= short_vs;
      sv_q      <= sv_s1_q;
      sa_s1_q   <= short_across;
      sa_q      <= sa_s1_q;
      ol_s1_q   <= open_load;
      ol_q      <= ol_s1_q;
      th_s1_q   <= thermal_warn;
      th_q      <= th_s1_q;
      stby_s1_q <= standby_pin;
      stby_q    <= stby_s1_q;
    end
  end

  // ==========================================================
  // control decode
  // ==========================================================
  logic ac_en, low_th, ssr_en, diag_en, off_en, stby_cmd, offset_start;
  logic [NUM_CH-1:0] pulse_hit;

  assign ac_en    = second_instruction_byte[IB2_AC_EN];
  assign low_th   = second_instruction_byte[IB2_LOW_TH];
  assign ssr_en   = second_instruction_byte[IB2_SSR_EN];
  assign diag_en  = first_instruction_byte[IB1_DIAG_EN];
  assign off_en   = first_instruction_byte[IB1_OFFSET_EN];
  // standby from pin or from a cleared serial standby-off bit
  assign stby_cmd = stby_q | ~second_instruction_byte[IB2_STBY_OFF];
  assign offset_start = instr_wr & off_en;
  // low threshold counts the 250 mA comparator, high one the 500 mA
  assign pulse_hit = low_th ? lo_rise : hi_rise;

  // ==========================================================
  // ac load detection
  // ==========================================================
  logic [1:0] pcnt_q [NUM_CH];
  logic [NUM_CH-1:0] ac_abort_q, ac_act_q;
  logic ac_en_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ac_en_q <= 1'b0;
    end else begin
      ac_en_q <= ac_en;
    end
  end

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ac
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          pcnt_q[g]     <= 2'h0;
          ac_abort_q[g] <= 1'b0;
          ac_act_q[g]   <= 1'b0;
          ac_open_q[g]  <= 1'b0;
        end else if (host_read) begin
          // the measuring period ends here; result latched for next read
          if (ac_act_q[g] && !ac_abort_q[g]) begin
            ac_open_q[g] <= (pcnt_q[g] != AC_CONFIRM_CNT);
          end
          pcnt_q[g]     <= 2'h0;
          ac_abort_q[g] <= 1'b0;
          ac_act_q[g]   <= ac_en;
        end else if (ac_en && !ac_en_q) begin
          pcnt_q[g]     <= 2'h0;
          ac_abort_q[g] <= 1'b0;
          ac_act_q[g]   <= 1'b1;
        end else if (!ac_en) begin
          ac_act_q[g]   <= 1'b0;
        end else begin
          if (sp_q[g]) begin
            ac_abort_q[g] <= 1'b1;
          end
          if (pulse_hit[g] && pcnt_q[g] != AC_CONFIRM_CNT) begin
            pcnt_q[g] <= pcnt_q[g] + 2'h1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // offset test in normal operation
  // ==========================================================
  logic [NUM_CH-1:0] off_persist_q;
  logic              off_win_q, off_abort_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      off_win_q      <= 1'b0;
      off_abort_q    <= 1'b0;
      off_persist_q  <= '0;
      offset_fault_q <= '0;
    end else if (host_read) begin
      if (off_win_q && !off_abort_q) begin
        offset_fault_q <= off_persist_q & off_q;
      end
      off_win_q     <= off_en;
      off_abort_q   <= 1'b0;
      off_persist_q <= '1;
    end else if (offset_start && !off_win_q) begin
      off_win_q     <= 1'b1;
      off_abort_q   <= 1'b0;
      off_persist_q <= '1;
    end else if (off_win_q) begin
      off_persist_q <= off_persist_q & off_q;
      if (|sp_q) begin
        off_abort_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // fault stability and priority
  // ==========================================================
  logic [NUM_CH-1:0] st_gnd_q, st_vs_q, st_acr_q, st_open_q;
  logic [NUM_CH*3-1:0] code_now;

  always_ff @(posedge ref_clk) begin
    if (reset || host_read) begin
      // new cycle starts from the read; stable-throughout tracking resets
      st_gnd_q  <= '1;
      st_vs_q   <= '1;
      st_acr_q  <= '1;
      st_open_q <= '1;
    end else begin
      st_gnd_q  <= st_gnd_q & sg_q;
      st_vs_q   <= st_vs_q & sv_q;
      st_acr_q  <= st_acr_q & sa_q;
      st_open_q <= st_open_q & ol_q & {NUM_CH{turn_on_phase}};
    end
  end

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_pri
      always_comb begin
        if (st_gnd_q[g] && st_vs_q[g]) begin
          code_now[g*3 +: 3] = FLT_BOTH;
        end else if (st_vs_q[g]) begin
          code_now[g*3 +: 3] = FLT_VS;
        end else if (st_gnd_q[g]) begin
          code_now[g*3 +: 3] = FLT_GND;
        end else if (st_acr_q[g]) begin
          code_now[g*3 +: 3] = FLT_ACROSS;
        end else if (st_open_q[g]) begin
          code_now[g*3 +: 3] = FLT_OPEN;
        end else begin
          code_now[g*3 +: 3] = FLT_NONE;
        end
      end
    end
  endgenerate

  // each channel carries its own highest fault; lower ones show after
  // the higher one is removed, from the next read on
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fault_code_q <= '0;
    end else if (host_read) begin
      fault_code_q <= diag_en ? code_now : '0;
    end
  end

  // ==========================================================
  // speaker safety routine
  // ==========================================================
  typedef enum logic [1:0] {
    SSR_IDLE  = 2'b00,
    SSR_CHECK = 2'b01,
    SSR_OFF   = 2'b10,
    SSR_RUN   = 2'b11
  } ssr_state_e;

  ssr_state_e ssr_q;
  logic [21:0] ssr_cnt_q;
  logic        ssr_trip_q;

  always_ff @(posedge ref_clk) begin
    if (reset || stby_cmd) begin
      ssr_q      <= SSR_IDLE;
      ssr_cnt_q  <= '0;
      ssr_trip_q <= 1'b0;
    end else begin
      case (ssr_q)
        SSR_IDLE: begin
          if (play_cmd && ssr_en) begin
            ssr_q     <= SSR_CHECK;
            ssr_cnt_q <= '0;
          end else if (play_cmd) begin
            ssr_q <= SSR_RUN;
          end
        end
        SSR_CHECK: begin
          if (|off_q) begin
            ssr_q      <= SSR_OFF;
            ssr_trip_q <= 1'b1;
          end else if (ssr_cnt_q == 22'(SSR_OFF_CYC - 1)) begin
            ssr_q <= SSR_RUN;
          end else begin
            ssr_cnt_q <= ssr_cnt_q + 22'h1;
          end
        end
        SSR_OFF: ssr_q <= SSR_OFF;
        SSR_RUN: ssr_q <= SSR_RUN;
        default: ssr_q <= SSR_IDLE;
      endcase
    end
  end

  assign amp_enable = ~stby_cmd & (ssr_q != SSR_OFF);

  always_comb begin
    second_diagnostic_byte             = 8'h00;
    second_diagnostic_byte[DB_SSR_OFF] = ssr_trip_q;
    second_diagnostic_byte[DB_AC_OPEN] = ac_open_q[1];
    second_diagnostic_byte[DB_THERM1]  = thermal_q[1];
  end

  // ==========================================================
  // thermal flags
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      thermal_q <= '0;
    end else begin
      thermal_q <= th_q;
    end
  end

  // ==========================================================
  // mute timing
  // ==========================================================
  logic [19:0] mute_cnt_q;
  logic        mute_req, mute_req_q;

  assign mute_req  = ~(first_instruction_byte[IB1_UNMUTE_REAR] & first_instruction_byte[IB1_UNMUTE_FRNT]);
  assign fast_mute = second_instruction_byte[IB2_FAST_MUTE];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mute_req_q  <= 1'b1;
      mute_cnt_q  <= '0;
      mute_active <= 1'b0;
    end else begin
      mute_req_q <= mute_req;
      if (mute_req && !mute_req_q) begin
        mute_active <= 1'b1;
        // fast ramp loads one cycle short so it stays strictly below 1.5 ms
        mute_cnt_q  <= fast_mute ? 20'(FAST_MUTE_CYC - 2) : 20'(NORM_MUTE_CYC - 1);
      end else if (mute_cnt_q != 20'h0) begin
        mute_cnt_q <= mute_cnt_q - 20'h1;
      end else begin
        mute_active <= 1'b0;
      end
    end
  end

endmodule

/* dv/amp_diag_props.sv */
// port assertions for the amplifier diagnostic control
`timescale 1ns/100ps
module amp_diag_props
  import amp_diag_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                reset,
  input wire logic [7:0]          second_instruction_byte,
  input wire logic                host_read,
  input wire logic                standby_pin,
  input wire logic                play_cmd,
  input wire logic [NUM_CH-1:0]   offset_over,
  input wire logic [2:0]          thermal_warn,
  input wire logic                amp_enable,
  input wire logic                fast_mute,
  input wire logic [NUM_CH-1:0]   ac_open_q,
  input wire logic [NUM_CH-1:0]   offset_fault_q,
  input wire logic [NUM_CH*3-1:0] fault_code_q,
  input wire logic [7:0]          second_diagnostic_byte,
  input wire logic [2:0]          thermal_q
);
  // ==========================================
  // cycles since reset, so delayed compares skip reset
  logic [2:0] up_q;
  always_ff @(posedge ref_clk) begin
    if (reset) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========================================
  // assertions
  a_fast_mute_bit: assert property (fast_mute == second_instruction_byte[IB2_FAST_MUTE])
    else $error("fast mute differs from its bit");
  a_ch1_open_bit: assert property (second_diagnostic_byte[DB_AC_OPEN] == ac_open_q[1])
    else $error("ch1 open bit differs");
  a_therm_flag_bit: assert property (second_diagnostic_byte[DB_THERM1] == thermal_q[1])
    else $error("thermal flag bit differs");
  a_therm_delay: assert property (up_q == 3'h7 |-> thermal_q == $past(thermal_warn, 3))
    else $error("thermal flags late or wrong");
  a_result_hold: assert property ($changed({ac_open_q, offset_fault_q, fault_code_q}) |-> $past(host_read))
    else $error("results moved without a read");
  a_stby_amp_off: assert property (standby_pin [*4] |-> !amp_enable)
    else $error("amplifier on in standby");
  a_stby_clears: assert property (standby_pin [*6] |-> !second_diagnostic_byte[DB_SSR_OFF])
    else $error("shutdown flag kept in standby");
  a_ssr_trip: assert property (play_cmd && second_instruction_byte[IB2_SSR_EN] && !standby_pin
    && second_instruction_byte[IB2_STBY_OFF] && offset_over != 4'h0 && up_q == 3'h7
    |-> ##[1:6] !amp_enable)
    else $error("no shutdown on offset");
  a_ssr_flag: assert property ($fell(amp_enable) && !standby_pin && second_instruction_byte[IB2_STBY_OFF]
    |-> ##[0:2] second_diagnostic_byte[DB_SSR_OFF])
    else $error("shutdown not flagged");
  c_trip: cover property (play_cmd ##[1:6] !amp_enable);
  c_open: cover property (host_read ##1 ac_open_q != 4'h0);
  c_fault: cover property (host_read ##1 fault_code_q != 12'h000);
endmodule
bind amp_output_diagnostics_ctrl amp_diag_props u_props (
  .ref_clk(ref_clk), .reset(reset), .second_instruction_byte(second_instruction_byte),
  .host_read(host_read), .standby_pin(standby_pin), .play_cmd(play_cmd), .offset_over(offset_over),
  .thermal_warn(thermal_warn), .amp_enable(amp_enable), .fast_mute(fast_mute), .ac_open_q(ac_open_q),
  .offset_fault_q(offset_fault_q), .fault_code_q(fault_code_q),
  .second_diagnostic_byte(second_diagnostic_byte), .thermal_q(thermal_q));

/* dv/tone_source.sv */
// test tone model: output current peaks seen by the comparators
`timescale 1ns/100ps
module tone_source (
  input  wire logic       go,
  input  wire logic       use_hi,
  input  wire logic       use_lo,
  input  wire logic [3:0] n_cycles,
  output logic      [3:0] peak_hi,
  output logic      [3:0] peak_lo
);
  // ==========================================
  // tone
  // no tone means no current, so both comparators rest low
  initial begin
    peak_hi = 4'h0;
    peak_lo = 4'h0;
  end
  // a peak above the high level is also above the low one
  always @(posedge go) begin
    // step off the clock edge so the comparator pins never move on a sampling edge
    #5;
    for (int i = 0; i < n_cycles; i++) begin
      #80 peak_hi = {4{use_hi}};
      peak_lo = {4{use_lo | use_hi}};
      #80 peak_hi = 4'h0;
      peak_lo = 4'h0;
    end
  end
endmodule

/* dv/amp_output_diagnostics_ctrl_tb.sv */
// self-checking bench for the amplifier diagnostic control
`timescale 1ns/100ps
module amp_output_diagnostics_ctrl_tb;
  import amp_diag_pkg::*;
  logic        ref_clk, reset, instr_wr, host_read, standby_pin, play_cmd, turn_on_phase;
  logic        tone_go, use_hi, use_lo, amp_enable, mute_active, fast_mute;
  logic [3:0]  tone_n, offset_over, short_prot, short_gnd, short_vs, short_across, open_load;
  logic [3:0]  peak_hi, peak_lo, ac_open_q, offset_fault_q;
  logic [7:0]  first_instr, second_instr, diag_byte;
  logic [2:0]  thermal_warn, thermal_q;
  logic [11:0] fault_code_q;
  int          err_total, tests_run, cyc;

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  amp_output_diagnostics_ctrl DUT (.ref_clk(ref_clk), .reset(reset), .first_instruction_byte(first_instr),
    .second_instruction_byte(second_instr), .instr_wr(instr_wr), .host_read(host_read),
    .standby_pin(standby_pin), .play_cmd(play_cmd), .turn_on_phase(turn_on_phase), .peak_above_hi(peak_hi),
    .peak_above_lo(peak_lo), .offset_over(offset_over), .short_prot(short_prot), .short_gnd(short_gnd),
    .short_vs(short_vs), .short_across(short_across), .open_load(open_load), .thermal_warn(thermal_warn),
    .amp_enable(amp_enable), .mute_active(mute_active), .fast_mute(fast_mute), .ac_open_q(ac_open_q),
    .offset_fault_q(offset_fault_q), .fault_code_q(fault_code_q), .second_diagnostic_byte(diag_byte),
    .thermal_q(thermal_q));
  tone_source u_tone (.go(tone_go), .use_hi(use_hi), .use_lo(use_lo), .n_cycles(tone_n),
    .peak_hi(peak_hi), .peak_lo(peak_lo));

  // ==========================================
  // shared tasks
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic rd();
    @(posedge ref_clk) host_read <= 1'b1;
    @(posedge ref_clk) host_read <= 1'b0;
  endtask
  task automatic wr2(input logic [7:0] v);
    @(posedge ref_clk) begin
      second_instr <= v;
      instr_wr <= 1'b1;
    end
    @(posedge ref_clk) instr_wr <= 1'b0;
  endtask
  task automatic play();
    @(posedge ref_clk) play_cmd <= 1'b1;
    @(posedge ref_clk) play_cmd <= 1'b0;
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================
  // scenarios
  // period opens on the enable edge; an overload holds the old result
  task automatic ac_meas(input logic [7:0] mode, input logic hi, lo, sp, input logic [3:0] n, exp);
    wr2(mode);
    wr2(mode | 8'h04);
    tick(4);
    @(posedge ref_clk) begin
      use_hi <= hi;
      use_lo <= lo;
      tone_n <= n;
      tone_go <= 1'b1;
    end
    tick(2);
    tone_go <= 1'b0;
    if (sp) short_prot <= 4'hf;
    tick(n * 8 + 8);
    short_prot <= 4'h0;
    tick(4);
    rd();
    tick(2);
    check(ac_open_q, exp, "ac open result");
    check(diag_byte[DB_AC_OPEN], exp[1], "ch1 open bit");
  endtask
  // faults are set just before a read so a whole period sees them
  task automatic fault_pass(input logic t, input logic [3:0] g, v, a, o, off, input logic [11:0] exp);
    turn_on_phase <= t;
    short_gnd <= g;
    short_vs <= v;
    short_across <= a;
    open_load <= o;
    offset_over <= off;
    tick(4);
    rd();
    tick(10);
    rd();
    tick(10);
    rd();
    tick(2);
    check(fault_code_q, exp, "fault codes");
    check(offset_fault_q, off, "offset faults");
  endtask
  // a short that comes and goes inside one period is not reported
  task automatic transient_fault();
    short_across <= 4'h2;
    tick(4);
    rd();
    tick(4);
    short_gnd <= 4'h1;
    tick(4);
    short_gnd <= 4'h0;
    tick(6);
    rd();
    tick(2);
    check(fault_code_q, 12'h010, "transient short reported");
    short_across <= 4'h0;
  endtask
  task automatic ssr_test();
    wr2(8'h10);
    offset_over <= 4'h1;
    tick(4);
    play();
    tick(20);
    check(amp_enable, 1'b1, "amp off with routine disabled");
    standby_pin <= 1'b1;
    tick(8);
    check(amp_enable, 1'b0, "amp on in standby");
    standby_pin <= 1'b0;
    wr2(8'h11);
    tick(8);
    play();
    for (int i = 0; i < 20 && amp_enable !== 1'b0; i++) tick(1);
    check(amp_enable, 1'b0, "no shutdown on offset");
    check(diag_byte[DB_SSR_OFF], 1'b1, "shutdown flag");
    offset_over <= 4'h0;
    standby_pin <= 1'b1;
    tick(8);
    standby_pin <= 1'b0;
    tick(8);
    check(diag_byte[DB_SSR_OFF], 1'b0, "flag kept after standby");
    check(amp_enable, 1'b1, "amp not restored");
  endtask
  task automatic misc_test();
    thermal_warn <= 3'b101;
    tick(6);
    check(thermal_q, 3'b101, "thermal flags");
    check(diag_byte[DB_THERM1], 1'b0, "thermal bit");
    thermal_warn <= 3'b010;
    tick(6);
    check(diag_byte[DB_THERM1], 1'b1, "thermal bit");
    wr2(8'h30);
    tick(2);
    check(fast_mute, 1'b1, "fast mute");
    // unmute, then mute with the fast option: the ramp must end inside 1.5 ms
    first_instr <= 8'h66;
    tick(4);
    check(mute_active, 1'b0, "mute active while playing");
    first_instr <= 8'h60;
    tick(2);
    check(mute_active, 1'b1, "mute ramp not started");
    tick(FAST_MUTE_CYC - 1);
    check(mute_active, 1'b0, "fast mute ramp too long");
    wr2(8'h10);
    tick(2);
    check(fast_mute, 1'b0, "fast mute kept");
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    {reset, instr_wr, host_read, standby_pin, play_cmd, turn_on_phase, tone_go, use_hi, use_lo} = 9'h100;
    {tone_n, offset_over, short_prot, short_gnd, short_vs, short_across, open_load} = 28'h0;
    first_instr = 8'h00;
    second_instr = 8'h10;
    thermal_warn = 3'h0;
    tick(12);
    reset <= 1'b0;
    tick(4);
    first_instr <= 8'h60;
    ac_meas(8'h10, 1'b1, 1'b0, 1'b0, 4'h3, 4'h0);
    ac_meas(8'h10, 1'b1, 1'b0, 1'b0, 4'h2, 4'hf);
    ac_meas(8'h10, 1'b0, 1'b1, 1'b0, 4'h4, 4'hf);
    ac_meas(8'h90, 1'b0, 1'b1, 1'b0, 4'h3, 4'h0);
    ac_meas(8'h90, 1'b0, 1'b0, 1'b1, 4'h0, 4'h0);
    ac_meas(8'h10, 1'b1, 1'b0, 1'b0, 4'h9, 4'h0);
    fault_pass(1'b1, 4'h3, 4'ha, 4'h1, 4'hc, 4'h2, {FLT_VS, FLT_OPEN, FLT_BOTH, FLT_GND});
    fault_pass(1'b0, 4'h3, 4'ha, 4'h1, 4'hc, 4'h2, {FLT_VS, FLT_NONE, FLT_BOTH, FLT_GND});
    fault_pass(1'b0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 12'h002);
    fault_pass(1'b0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 12'h000);
    transient_fault();
    misc_test();
    ssr_test();
    final_report();
  end
  // the fast mute wait dominates: the whole run takes about 76,000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      final_report();
    end
  end
endmodule
